/* shared/dds_pkg.sv */
/*
 * constants for the dual converter serial write port: frame layout,
 * register map, reset values and crossing depths.
 * assumes a 32-bit axi4-lite register bus and byte addresses.
 */
package dds_pkg;

    // ------------------------------------------------------------------
    // serial frame layout
    // ------------------------------------------------------------------
    localparam int DDS_FRAME_BITS = 24;
    localparam int DDS_DATA_BITS = 16;
    localparam int DDS_CNT_W = 5;
    localparam int DDS_BIT_RSV_HI = 23;
    localparam int DDS_BIT_RSV_LO = 22;
    localparam int DDS_BIT_LOAD_B = 21;
    localparam int DDS_BIT_LOAD_A = 20;
    localparam int DDS_BIT_BUF_SEL = 18;
    localparam int DDS_BIT_PD_HI = 17;
    localparam int DDS_BIT_PD_LO = 16;

    // ------------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] DDS_OFS_CTRL = 8'h00;
    localparam logic [7:0] DDS_OFS_STATUS = 8'h04;
    localparam logic [7:0] DDS_OFS_DAC_A = 8'h08;
    localparam logic [7:0] DDS_OFS_DAC_B = 8'h0c;
    localparam logic [7:0] DDS_OFS_BUF_A = 8'h10;
    localparam logic [7:0] DDS_OFS_BUF_B = 8'h14;
    localparam logic [7:0] DDS_OFS_LAST = 8'h14;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int DDS_CTRL_ACCEPT = 0;
    localparam int DDS_STAT_RSV_ERR = 0;
    localparam int DDS_STAT_DROPPED = 1;
    localparam int DDS_STAT_ACTIVE = 2;
    localparam int DDS_STAT_CNT_LO = 16;
    localparam logic DDS_CTRL_ACCEPT_RST = 1'b1;
    localparam logic [15:0] DDS_CODE_RST = 16'h0000;
    localparam logic [1:0] DDS_PD_RST = 2'h0;

    // ------------------------------------------------------------------
    // bus answers and crossing
    // ------------------------------------------------------------------
    localparam logic [1:0] DDS_RESP_OKAY = 2'h0;
    localparam logic [1:0] DDS_RESP_SLVERR = 2'h2;
    localparam int DDS_SYNC_STAGES = 2;

endpackage

/* core/dds_frame_rx.sv */
/*
 * link-side receiver: shifts serial bits on falling edges of the serial
 * clock and publishes each complete frame with a toggle.
 * assumes the serial clock only runs while the frame select is low or
 * just after a frame; the frame select resets the bit count directly.
 */
`timescale 1ns/100ps
`default_nettype none

module dds_frame_rx import dds_pkg::*; #(
    parameter int FRAME_BITS = DDS_FRAME_BITS
) (
    input wire logic serial_shift_clock,
    input wire logic rst_n,
    input wire logic frame_select_n,
    input wire logic serial_data_in,
    output logic [FRAME_BITS-1:0] word_r,
    output logic done_tgl_r
);

    initial begin
        if (FRAME_BITS < 2 || FRAME_BITS > 31) begin
            $error("frame width out of range");
        end
    end

    // ------------------------------------------------------------------
    // frame bit counter
    // ------------------------------------------------------------------
    logic frame_clr;
    logic [DDS_CNT_W-1:0] cnt_r;
    logic [DDS_CNT_W-1:0] cnt_nxt;
    logic [FRAME_BITS-1:0] sh_r;
    logic [FRAME_BITS-1:0] sh_nxt;
    logic [FRAME_BITS-1:0] word_nxt;
    logic done_tgl_nxt;
    logic shifting;
    logic last_bit;

    // select high holds the counter at zero
    assign frame_clr = frame_select_n | ~rst_n;
    assign shifting = !frame_select_n &&
                      (cnt_r < DDS_CNT_W'(FRAME_BITS));
    assign last_bit = (cnt_r == DDS_CNT_W'(FRAME_BITS - 1));

    always_comb begin
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        word_nxt = word_r;
        done_tgl_nxt = done_tgl_r;
        if (shifting) begin
            cnt_nxt = cnt_r + DDS_CNT_W'(1);
            sh_nxt = {sh_r[FRAME_BITS-2:0], serial_data_in};
        end
        if (last_bit) begin
            word_nxt = {sh_r[FRAME_BITS-2:0], serial_data_in};
            done_tgl_nxt = ~done_tgl_r;
        end
    end

    always_ff @(negedge serial_shift_clock or posedge frame_clr) begin
        if (frame_clr) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // shift and hold registers
    // ------------------------------------------------------------------
    always_ff @(negedge serial_shift_clock or negedge rst_n) begin
        if (!rst_n) begin
            sh_r <= '0;
            word_r <= '0;
            done_tgl_r <= 1'b0;
        end else begin
            sh_r <= sh_nxt;
            word_r <= word_nxt;
            done_tgl_r <= done_tgl_nxt;
        end
    end

endmodule

`default_nettype wire

/* core/dds_top.sv */
/*
 * dual converter serial write port: link receiver, frame decode into
 * data buffers and channel registers, axi4-lite register slave.
 * assumes ref_clk at 125 MHz, rst_n asynchronous active low, and a
 * serial clock unrelated to ref_clk.
 */
//
// Notes on behaviour
// - select low enables shifting; high accepts nothing
// - sample data each falling clock, 24 bits
// - frame is control byte plus 16-bit data
// - act after 24th falling edge, no wait
// - early select rise drops frame, no update
// - top two control bits must be zero
// - load bits update outputs; bit 18 picks buffer
// - after 24 bits the word is locked
// - new frame starts at next select fall
`timescale 1ns/100ps
`default_nettype none

module dds_top import dds_pkg::*; #(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic serial_shift_clock,
    input wire logic frame_select_n,
    input wire logic serial_data_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [15:0] dac_a_code,
    output logic [15:0] dac_b_code,
    output logic [1:0] dac_a_pd,
    output logic [1:0] dac_b_pd,
    output logic dac_update
);

    initial begin
        if (ADDR_W < 5 || ADDR_W > 32) begin
            $error("address width out of range");
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] pack_chan(input logic [15:0] code,
                                              input logic [1:0] pd);
        pack_chan = {14'h0000, pd, code};
    endfunction

    function automatic logic [7:0] low_ofs(input logic [ADDR_W-1:0] a);
        logic [31:0] w;
        w = 32'(a);
        low_ofs = {w[7:2], 2'h0};
    endfunction

    // ------------------------------------------------------------------
    // link domain receiver
    // ------------------------------------------------------------------
    logic [DDS_FRAME_BITS-1:0] link_word;
    logic link_tgl;

    dds_frame_rx #(
        .FRAME_BITS(DDS_FRAME_BITS)
    ) u_rx (
        .serial_shift_clock(serial_shift_clock),
        .rst_n(rst_n),
        .frame_select_n(frame_select_n),
        .serial_data_in(serial_data_in),
        .word_r(link_word),
        .done_tgl_r(link_tgl)
    );

    // ------------------------------------------------------------------
    // crossing into ref_clk
    // ------------------------------------------------------------------
    logic tgl_s1_r;
    logic tgl_s2_r;
    logic tgl_s3_r;
    logic fs_s1_r;
    logic fs_s2_r;
    logic frame_evt;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
            fs_s1_r <= 1'b1;
            fs_s2_r <= 1'b1;
        end else begin
            tgl_s1_r <= link_tgl;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
            fs_s1_r <= frame_select_n;
            fs_s2_r <= fs_s1_r;
        end
    end

    // word is held stable for a whole frame after its toggle
    assign frame_evt = tgl_s2_r ^ tgl_s3_r;

    // ------------------------------------------------------------------
    // frame decode and channel state
    // ------------------------------------------------------------------
    logic accept_r;
    logic accept_nxt;
    logic [15:0] buf_a_r;
    logic [15:0] buf_a_nxt;
    logic [15:0] buf_b_r;
    logic [15:0] buf_b_nxt;
    logic [1:0] bpd_a_r;
    logic [1:0] bpd_a_nxt;
    logic [1:0] bpd_b_r;
    logic [1:0] bpd_b_nxt;
    logic [15:0] dac_a_nxt;
    logic [15:0] dac_b_nxt;
    logic [1:0] dac_a_pd_nxt;
    logic [1:0] dac_b_pd_nxt;
    logic dac_update_nxt;
    logic rsv_err_r;
    logic rsv_err_nxt;
    logic dropped_r;
    logic dropped_nxt;
    logic [15:0] frame_cnt_r;
    logic [15:0] frame_cnt_nxt;
    logic wr_fire;
    logic [7:0] wr_ofs;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [15:0] f_data;
    logic [1:0] f_pd;
    logic f_rsv_bad;

    assign f_data = link_word[DDS_DATA_BITS-1:0];
    assign f_pd = link_word[DDS_BIT_PD_HI:DDS_BIT_PD_LO];
    assign f_rsv_bad = link_word[DDS_BIT_RSV_HI] |
                       link_word[DDS_BIT_RSV_LO];

    always_comb begin
        accept_nxt = accept_r;
        buf_a_nxt = buf_a_r;
        buf_b_nxt = buf_b_r;
        bpd_a_nxt = bpd_a_r;
        bpd_b_nxt = bpd_b_r;
        dac_a_nxt = dac_a_code;
        dac_b_nxt = dac_b_code;
        dac_a_pd_nxt = dac_a_pd;
        dac_b_pd_nxt = dac_b_pd;
        dac_update_nxt = 1'b0;
        rsv_err_nxt = rsv_err_r;
        dropped_nxt = dropped_r;
        frame_cnt_nxt = frame_cnt_r;
        // software clears first so a same-cycle event wins
        if (wr_fire && wr_ofs == DDS_OFS_CTRL && wr_strb[0]) begin
            accept_nxt = wr_data[DDS_CTRL_ACCEPT];
        end else if (wr_fire && wr_ofs == DDS_OFS_STATUS && wr_strb[0]) begin
            if (wr_data[DDS_STAT_RSV_ERR]) begin
                rsv_err_nxt = 1'b0;
            end
            if (wr_data[DDS_STAT_DROPPED]) begin
                dropped_nxt = 1'b0;
            end
        end
        if (frame_evt) begin
            frame_cnt_nxt = frame_cnt_r + 16'h0001;
            if (f_rsv_bad) begin
                rsv_err_nxt = 1'b1;
            end else if (!accept_r) begin
                dropped_nxt = 1'b1;
            end else begin
                if (link_word[DDS_BIT_BUF_SEL]) begin
                    buf_b_nxt = f_data;
                    bpd_b_nxt = f_pd;
                end else begin
                    buf_a_nxt = f_data;
                    bpd_a_nxt = f_pd;
                end
                if (link_word[DDS_BIT_LOAD_A]) begin
                    dac_a_nxt = buf_a_nxt;
                    dac_a_pd_nxt = bpd_a_nxt;
                end
                if (link_word[DDS_BIT_LOAD_B]) begin
                    dac_b_nxt = buf_b_nxt;
                    dac_b_pd_nxt = bpd_b_nxt;
                end
                dac_update_nxt = link_word[DDS_BIT_LOAD_A] |
                                 link_word[DDS_BIT_LOAD_B];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            accept_r <= DDS_CTRL_ACCEPT_RST;
            buf_a_r <= DDS_CODE_RST;
            buf_b_r <= DDS_CODE_RST;
            bpd_a_r <= DDS_PD_RST;
            bpd_b_r <= DDS_PD_RST;
            dac_a_code <= DDS_CODE_RST;
            dac_b_code <= DDS_CODE_RST;
            dac_a_pd <= DDS_PD_RST;
            dac_b_pd <= DDS_PD_RST;
            dac_update <= 1'b0;
            rsv_err_r <= 1'b0;
            dropped_r <= 1'b0;
            frame_cnt_r <= 16'h0000;
        end else begin
            accept_r <= accept_nxt;
            buf_a_r <= buf_a_nxt;
            buf_b_r <= buf_b_nxt;
            bpd_a_r <= bpd_a_nxt;
            bpd_b_r <= bpd_b_nxt;
            dac_a_code <= dac_a_nxt;
            dac_b_code <= dac_b_nxt;
            dac_a_pd <= dac_a_pd_nxt;
            dac_b_pd <= dac_b_pd_nxt;
            dac_update <= dac_update_nxt;
            rsv_err_r <= rsv_err_nxt;
            dropped_r <= dropped_nxt;
            frame_cnt_r <= frame_cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    logic aw_hold_r;
    logic aw_hold_nxt;
    logic w_hold_r;
    logic w_hold_nxt;
    logic [7:0] aw_ofs_r;
    logic [7:0] aw_ofs_nxt;
    logic [31:0] wdata_r;
    logic [31:0] wdata_nxt;
    logic [3:0] wstrb_r;
    logic [3:0] wstrb_nxt;
    logic awready_nxt;
    logic wready_nxt;
    logic bvalid_nxt;
    logic [1:0] bresp_nxt;

    assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign wr_ofs = aw_ofs_r;
    assign wr_data = wdata_r;
    assign wr_strb = wstrb_r;

    always_comb begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt = w_hold_r;
        aw_ofs_nxt = aw_ofs_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = s_axi_bvalid;
        bresp_nxt = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_nxt = 1'b1;
            aw_ofs_nxt = low_ofs(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (wr_fire) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            if (aw_ofs_r == DDS_OFS_CTRL || aw_ofs_r == DDS_OFS_STATUS) begin
                bresp_nxt = DDS_RESP_OKAY;
            end else if (aw_ofs_r <= DDS_OFS_LAST) begin
                bresp_nxt = DDS_RESP_OKAY;
            end else begin
                bresp_nxt = DDS_RESP_SLVERR;
            end
        end
        awready_nxt = !aw_hold_nxt;
        wready_nxt = !w_hold_nxt;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_ofs_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= DDS_RESP_OKAY;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            aw_ofs_r <= aw_ofs_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            s_axi_awready <= awready_nxt;
            s_axi_wready <= wready_nxt;
            s_axi_bvalid <= bvalid_nxt;
            s_axi_bresp <= bresp_nxt;
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    logic arready_nxt;
    logic rvalid_nxt;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_nxt;
    logic [7:0] rd_ofs;

    always_comb begin
        rvalid_nxt = s_axi_rvalid;
        rdata_nxt = s_axi_rdata;
        rresp_nxt = s_axi_rresp;
        rd_ofs = low_ofs(s_axi_araddr);
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = DDS_RESP_OKAY;
            if (rd_ofs == DDS_OFS_CTRL) begin
                rdata_nxt = {31'h00000000, accept_r};
            end else if (rd_ofs == DDS_OFS_STATUS) begin
                rdata_nxt = {frame_cnt_r, 13'h0000, ~fs_s2_r,
                             dropped_r, rsv_err_r};
            end else if (rd_ofs == DDS_OFS_DAC_A) begin
                rdata_nxt = pack_chan(dac_a_code, dac_a_pd);
            end else if (rd_ofs == DDS_OFS_DAC_B) begin
                rdata_nxt = pack_chan(dac_b_code, dac_b_pd);
            end else if (rd_ofs == DDS_OFS_BUF_A) begin
                rdata_nxt = pack_chan(buf_a_r, bpd_a_r);
            end else if (rd_ofs == DDS_OFS_BUF_B) begin
                rdata_nxt = pack_chan(buf_b_r, bpd_b_r);
            end else begin
                rdata_nxt = 32'h00000000;
                rresp_nxt = DDS_RESP_SLVERR;
            end
        end
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= DDS_RESP_OKAY;
        end else begin
            s_axi_arready <= arready_nxt;
            s_axi_rvalid <= rvalid_nxt;
            s_axi_rdata <= rdata_nxt;
            s_axi_rresp <= rresp_nxt;
        end
    end

endmodule

`default_nettype wire

/* tb/dds_host_model.sv */
/* host serial master model for the write port.
   assumes falling-edge sampling and a 160 ns serial clock. */
`timescale 1ns/100ps
`default_nettype none
module dds_host_model (
    output logic serial_shift_clock,
    output logic frame_select_n,
    output logic serial_data_in
);
    // ------------------------------------------------------------
    // frame sender, clock idles high between frames
    // ------------------------------------------------------------
    initial begin
        serial_shift_clock <= 1'b1;
        frame_select_n <= 1'b1;
        serial_data_in <= 1'b0;
    end
    task automatic send(input logic [23:0] w, input int n, input int x);
        #3.7;
        frame_select_n = 1'b0;
        for (int i = 0; i < n + x; i++) begin
            serial_data_in = w[23 - (i % 24)] ^ (i >= 24);
            #40 serial_shift_clock = 1'b0;
            #80 serial_shift_clock = 1'b1;
            #40;
        end
        serial_data_in = ~serial_data_in;
        #120 frame_select_n = 1'b1;
        #80;
    endtask
endmodule
`default_nettype wire

/* tb/dds_top_assertions.sv */
/* port checks for the serial write port top.
   assumes a bind into dds_top, sampled on ref_clk. */
`timescale 1ns/100ps
`default_nettype none
module dds_top_assertions import dds_pkg::*; #(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] dac_a_code,
    input wire logic [15:0] dac_b_code,
    input wire logic [1:0] dac_a_pd,
    input wire logic [1:0] dac_b_pd,
    input wire logic dac_update
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_upd_pulse;
        dac_update |=> !dac_update;
    endproperty
    a_upd_pulse: assert property (p_upd_pulse)
        else $error("update pulse too long");
    property p_a_chg;
        $changed({dac_a_pd, dac_a_code}) |-> dac_update;
    endproperty
    a_a_chg: assert property (p_a_chg)
        else $error("channel a changed without update");
    property p_b_chg;
        $changed({dac_b_pd, dac_b_code}) |-> dac_update;
    endproperty
    a_b_chg: assert property (p_b_chg)
        else $error("channel b changed without update");
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped");
    property p_wr_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat)
        else $error("write answer late");
    property p_rd_err;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h05
            |=> s_axi_rresp == DDS_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_rd_err: assert property (p_rd_err)
        else $error("unmapped read not refused");
    c_upd: cover property (dac_update);
    c_rerr: cover property (s_axi_rvalid && s_axi_rresp == DDS_RESP_SLVERR);
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/* self-checking bench for the serial write port top.
   assumes the package, design, host model and checker compile first. */
`timescale 1ns/100ps
`default_nettype none
module tb_top import dds_pkg::*;;
    // ------------------------------------------------------------
    // stimulus, reference model and checking
    // ------------------------------------------------------------
    logic ref_clk = 1'b0, rst_n = 1'b1, acc = 1'b1;
    logic sck, fsn, sdi, awready, wready, bvalid, arready, rvalid, upd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, apd, bpd;
    logic [15:0] acode, bcode;
    logic [17:0] ba = '0, bb = '0, da = '0, db = '0;
    logic [35:0] dq[$];
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [23:0] w;
    int err_total = 0, tests_run = 0, cnt = 0;
    always #4 ref_clk = ~ref_clk;
    dds_host_model dds_host_model_inst (.serial_shift_clock(sck),
        .frame_select_n(fsn), .serial_data_in(sdi));
    dds_top dds_top_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .serial_shift_clock(sck), .frame_select_n(fsn), .serial_data_in(sdi),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .dac_a_code(acode), .dac_b_code(bcode),
        .dac_a_pd(apd), .dac_b_pd(bpd), .dac_update(upd));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        if (upd) begin
            if (dq.size() == 0) check(1, 0);
            else check({apd, acode, bpd, bcode}, dq.pop_front());
        end
        if (bvalid && bready) check(bresp, bq.pop_front());
        if (rvalid && rready) check({rresp, rdata}, rq.pop_front());
    end
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] e);
        int n;
        bq.push_back(e);
        n = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!(bvalid && bready) && n < 100);
        bready <= 1'b0;
        if (n >= 100) check(1, 0);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        rq.push_back(e);
        n = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!(rvalid && rready) && n < 100);
        rready <= 1'b0;
        if (n >= 100) check(1, 0);
    endtask
    task automatic frame(input logic [23:0] v, input int n, input int x);
        if (n == 24) begin
            cnt++;
            if (v[23:22] == 2'b00 && acc) begin
                if (v[18]) bb = v[17:0];
                else ba = v[17:0];
                if (v[20]) da = ba;
                if (v[21]) db = bb;
                if (v[21] || v[20]) dq.push_back({da, db});
            end
        end
        dds_host_model_inst.send(v, n, x);
        repeat (8) @(posedge ref_clk);
    endtask
    initial begin
        rst_n <= 1'b0;
        void'($urandom(32'h0939));
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        axi_rd(DDS_OFS_CTRL, {DDS_RESP_OKAY, 32'h1});
        axi_rd(DDS_OFS_STATUS, {DDS_RESP_OKAY, 32'h0});
        for (int i = 0; i < 12; i++) begin
            w = 24'($urandom()) & 24'h3fffff;
            frame(w, 24, 0);
        end
        frame(24'h30_1234, 24, 0);
        frame(24'h04_5a5a, 24, 0);
        axi_rd(DDS_OFS_BUF_B, {DDS_RESP_OKAY, 14'h0, bb});
        axi_rd(DDS_OFS_DAC_B, {DDS_RESP_OKAY, 14'h0, db});
        frame(24'h10_c3c3, 11, 0);
        fork
            frame(24'h00_0000, 11, 0);
            begin
                repeat (60) @(posedge ref_clk);
                axi_rd(DDS_OFS_STATUS, {DDS_RESP_OKAY, 16'(cnt), 16'h4});
            end
        join
        frame(24'h13_8001, 24, 5);
        for (int r = 1; r < 4; r++) begin
            frame({r[1:0], 22'h30_1111}, 24, 0);
        end
        axi_rd(DDS_OFS_STATUS, {DDS_RESP_OKAY, 16'(cnt), 16'h1});
        axi_wr(DDS_OFS_STATUS, 32'h3, DDS_RESP_OKAY);
        axi_wr(DDS_OFS_CTRL, 32'h0, DDS_RESP_OKAY);
        acc = 1'b0;
        frame(24'h30_7777, 24, 0);
        axi_rd(DDS_OFS_STATUS, {DDS_RESP_OKAY, 16'(cnt), 16'h2});
        axi_wr(DDS_OFS_CTRL, 32'h1, DDS_RESP_OKAY);
        axi_wr(DDS_OFS_STATUS, 32'h3, DDS_RESP_OKAY);
        acc = 1'b1;
        frame(24'h30_2468, 24, 0);
        axi_wr(8'h40, 32'h0, DDS_RESP_SLVERR);
        axi_rd(8'h3c, {DDS_RESP_SLVERR, 32'h0});
        axi_rd(DDS_OFS_DAC_A, {DDS_RESP_OKAY, 14'h0, da});
        repeat (8) @(posedge ref_clk);
        check(dq.size(), 0);
        give_verdict();
    end
    initial begin
        #600000;
        err_total++;
        give_verdict();
    end
endmodule
bind dds_top dds_top_assertions #(.ADDR_W(ADDR_W)) chk_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .dac_a_code(dac_a_code),
    .dac_b_code(dac_b_code), .dac_a_pd(dac_a_pd), .dac_b_pd(dac_b_pd),
    .dac_update(dac_update));
`default_nettype wire
